// ### pkg/ccd_pkg.sv
// constants and operation codes for the clear/compare/decrement datapath
// assumes the decoder presents one operation per instruction cycle
`default_nettype none
package ccd_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int CCD_DATA_W = 8;
	localparam int CCD_ADDR_W = 6;
	// ****************************************
	// values
	// ****************************************
	localparam logic [7:0] CCD_ACC_RST = 8'h00;
	localparam logic [7:0] CCD_CLEAR_VAL = 8'h00;
	localparam logic [7:0] CCD_DEC_STEP = 8'h01;
	localparam logic CCD_STATUS_N_RST = 1'b1;
	localparam logic CCD_FLAG_RST = 1'b0;
	localparam logic CCD_DEST_ACC = 1'b0;
	localparam logic CCD_DEST_REG = 1'b1;
	// ****************************************
	// operations
	// ****************************************
	typedef enum logic [2:0] {
		CCD_OP_NONE,
		CCD_CLEAR_ACCUMULATOR_OP,
		CCD_CLEAR_WATCHDOG_OP,
		CCD_CLEAR_REGISTER_OP,
		CCD_COMPLEMENT_REGISTER_OP,
		CCD_COMPARE_ACC_REGISTER_OP,
		CCD_DECREMENT_REGISTER_OP
	} ccd_op_t;
endpackage
`default_nettype wire

// ### rtl/ccd_alu.sv
// combinational result, zero and carry for one operation
// assumes operands are stable during the instruction cycle
`timescale 1ns/1ps
`default_nettype none
module ccd_alu #(
	parameter int DATA_W = ccd_pkg::CCD_DATA_W
) (
	input wire ccd_pkg::ccd_op_t op_i,
	input wire logic [DATA_W-1:0] acc_i,
	input wire logic [DATA_W-1:0] rdata_i,
	output logic [DATA_W-1:0] result_o,
	output logic zero_o,
	output logic carry_o
);
	import ccd_pkg::*;
	localparam logic [DATA_W-1:0] clear_val = DATA_W'(CCD_CLEAR_VAL);
	localparam logic [DATA_W-1:0] dec_step = DATA_W'(CCD_DEC_STEP);
	// extra top bit holds the borrow of the subtraction
	wire logic [DATA_W:0] diff = {1'b0, rdata_i} - {1'b0, acc_i};
	wire logic [DATA_W-1:0] dec = rdata_i - dec_step;
	always_comb begin
		result_o = clear_val;
		unique case (op_i)
			CCD_COMPLEMENT_REGISTER_OP: result_o = ~rdata_i;
			CCD_COMPARE_ACC_REGISTER_OP: result_o = diff[DATA_W-1:0];
			CCD_DECREMENT_REGISTER_OP: result_o = dec;
			CCD_OP_NONE, CCD_CLEAR_ACCUMULATOR_OP, CCD_CLEAR_WATCHDOG_OP, CCD_CLEAR_REGISTER_OP: result_o = clear_val;
			default: result_o = clear_val;
		endcase
	end
	assign zero_o = (result_o == clear_val);
	// carry means no borrow: register >= accumulator
	assign carry_o = ~diff[DATA_W];
endmodule
`default_nettype wire

// ### rtl/ccd_core.sv
// execution datapath for clear, complement, compare and decrement operations
// assumes the decoder, register file and watchdog share CLK_SYS_I
// register read data must belong to REG_ADDR_I in the cycle of OP_VALID_I
`timescale 1ns/1ps
`default_nettype none
module ccd_core #(
	parameter int DATA_W = ccd_pkg::CCD_DATA_W,
	parameter int ADDR_W = ccd_pkg::CCD_ADDR_W
) (
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	input wire logic OP_VALID_I,
	input wire ccd_pkg::ccd_op_t OP_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic DEST_I,
	input wire logic [DATA_W-1:0] REG_RDATA_I,
	input wire logic PRESCALER_TO_WDT_I,
	input wire logic WDT_TIMEOUT_I,
	input wire logic SLEEP_ENTER_I,
	output logic [DATA_W-1:0] ACC_O,
	output logic ZERO_FLAG_O,
	output logic CARRY_FLAG_O,
	output logic TIMEOUT_STATUS_N_O,
	output logic POWERDOWN_STATUS_N_O,
	output logic REG_WE_O,
	output logic [ADDR_W-1:0] REG_WADDR_O,
	output logic [DATA_W-1:0] REG_WDATA_O,
	output logic WDT_CLEAR_O,
	output logic PRESCALER_CLEAR_O,
	output logic DONE_O
);
	import ccd_pkg::*;

	// ****************************************
	// parameter checks
	// ****************************************
	if (DATA_W < 2 || ADDR_W < 1) begin : g_bad_param
		$error("ccd_core: DATA_W must be at least 2 and ADDR_W at least 1");
	end

	localparam logic [DATA_W-1:0] acc_rst = DATA_W'(CCD_ACC_RST);

	// ****************************************
	// decode
	// ****************************************
	wire logic take = OP_VALID_I && (OP_I != CCD_OP_NONE);
	wire logic is_clear_accumulator_op = take && (OP_I == CCD_CLEAR_ACCUMULATOR_OP);
	wire logic is_clear_watchdog_op = take && (OP_I == CCD_CLEAR_WATCHDOG_OP);
	wire logic is_clear_register_op = take && (OP_I == CCD_CLEAR_REGISTER_OP);
	wire logic is_complement_register_op = take && (OP_I == CCD_COMPLEMENT_REGISTER_OP);
	wire logic is_cmp = take && (OP_I == CCD_COMPARE_ACC_REGISTER_OP);
	wire logic is_decrement_register_op = take && (OP_I == CCD_DECREMENT_REGISTER_OP);
	wire logic to_acc = (is_complement_register_op || is_decrement_register_op) && (DEST_I == CCD_DEST_ACC);
	wire logic to_reg = (is_complement_register_op || is_decrement_register_op) && (DEST_I == CCD_DEST_REG);

	logic [DATA_W-1:0] alu_result;
	logic alu_zero;
	logic alu_carry;

	ccd_alu #(
		.DATA_W(DATA_W)
	) u_alu (
		.op_i(OP_I),
		.acc_i(ACC_O),
		.rdata_i(REG_RDATA_I),
		.result_o(alu_result),
		.zero_o(alu_zero),
		.carry_o(alu_carry)
	);

	// ****************************************
	// next values
	// ****************************************
	// compare loads neither acc nor the register write enable, so its difference only sets the zero and carry flags and REG_WDATA_O
	wire logic acc_load = is_clear_accumulator_op || to_acc;
	wire logic [DATA_W-1:0] acc_next = acc_load ? alu_result : ACC_O;
	wire logic zero_load = is_clear_accumulator_op || is_clear_register_op || is_complement_register_op || is_cmp || is_decrement_register_op;
	wire logic zero_next = zero_load ? alu_zero : ZERO_FLAG_O;
	wire logic carry_next = is_cmp ? alu_carry : CARRY_FLAG_O;
	// clear watchdog wins over a same-cycle timeout or sleep entry
	wire logic to_next = is_clear_watchdog_op ? 1'b1 : (WDT_TIMEOUT_I ? 1'b0 : TIMEOUT_STATUS_N_O);
	wire logic pd_next = is_clear_watchdog_op ? 1'b1 : (SLEEP_ENTER_I ? 1'b0 : POWERDOWN_STATUS_N_O);
	wire logic we_next = is_clear_register_op || to_reg;
	wire logic presc_next = is_clear_watchdog_op && PRESCALER_TO_WDT_I;

	// ****************************************
	// state
	// ****************************************
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			ACC_O <= acc_rst;
			ZERO_FLAG_O <= CCD_FLAG_RST;
			CARRY_FLAG_O <= CCD_FLAG_RST;
			TIMEOUT_STATUS_N_O <= CCD_STATUS_N_RST;
			POWERDOWN_STATUS_N_O <= CCD_STATUS_N_RST;
		end else begin
			ACC_O <= acc_next;
			ZERO_FLAG_O <= zero_next;
			CARRY_FLAG_O <= carry_next;
			TIMEOUT_STATUS_N_O <= to_next;
			POWERDOWN_STATUS_N_O <= pd_next;
		end
	end

	// strobes follow their op by one cycle; DONE_O stays high across back-to-back ops, the others only while each op raises them
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			REG_WE_O <= 1'b0;
			REG_WADDR_O <= '0;
			REG_WDATA_O <= '0;
			WDT_CLEAR_O <= 1'b0;
			PRESCALER_CLEAR_O <= 1'b0;
			DONE_O <= 1'b0;
		end else begin
			REG_WE_O <= we_next;
			REG_WADDR_O <= REG_ADDR_I;
			REG_WDATA_O <= alu_result;
			WDT_CLEAR_O <= is_clear_watchdog_op;
			PRESCALER_CLEAR_O <= presc_next;
			DONE_O <= take;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);

	AST_CLEAR_ACCUMULATOR_OP: assert property (is_clear_accumulator_op |=> ACC_O == '0 && ZERO_FLAG_O && CARRY_FLAG_O == $past(CARRY_FLAG_O))
		else $error("clear accumulator did not zero acc or set zero flag");
	AST_WDT_CLEAR: assert property (is_clear_watchdog_op |=> WDT_CLEAR_O ##1 !WDT_CLEAR_O || $past(is_clear_watchdog_op))
		else $error("watchdog clear strobe wrong");
	AST_PRESCALER: assert property (take |=> PRESCALER_CLEAR_O == $past(is_clear_watchdog_op && PRESCALER_TO_WDT_I))
		else $error("prescaler clear not tied to watchdog assignment");
	AST_STATUS: assert property (is_clear_watchdog_op |=> TIMEOUT_STATUS_N_O && POWERDOWN_STATUS_N_O
			&& ZERO_FLAG_O == $past(ZERO_FLAG_O) && CARRY_FLAG_O == $past(CARRY_FLAG_O))
		else $error("clear watchdog status bits wrong");
	AST_CLEAR_REGISTER_OP: assert property (is_clear_register_op |=> REG_WE_O && REG_WDATA_O == '0 && ZERO_FLAG_O
			&& REG_WADDR_O == $past(REG_ADDR_I) && ACC_O == $past(ACC_O))
		else $error("clear register write wrong");
	AST_COMPLEMENT_REGISTER_OP: assert property (is_complement_register_op |=> ZERO_FLAG_O == ($past(REG_RDATA_I) == {DATA_W{1'b1}})
			&& ($past(DEST_I) ? (REG_WE_O && REG_WDATA_O == ~$past(REG_RDATA_I) && ACC_O == $past(ACC_O))
			: (!REG_WE_O && ACC_O == ~$past(REG_RDATA_I))))
		else $error("complement result or destination wrong");
	AST_CMP_FLAGS: assert property (is_cmp |=> CARRY_FLAG_O == ($past(REG_RDATA_I) >= $past(ACC_O))
			&& ZERO_FLAG_O == ($past(REG_RDATA_I) == $past(ACC_O)))
		else $error("compare flags wrong");
	AST_CMP_KEEP: assert property (is_cmp |=> !REG_WE_O && ACC_O == $past(ACC_O))
		else $error("compare changed acc or register");
	AST_DECREMENT_REGISTER_OP: assert property (is_decrement_register_op |=> ZERO_FLAG_O == ($past(REG_RDATA_I) == DATA_W'(CCD_DEC_STEP))
			&& ($past(DEST_I) ? (REG_WE_O && REG_WDATA_O == DATA_W'($past(REG_RDATA_I) - DATA_W'(CCD_DEC_STEP)))
			: (!REG_WE_O && ACC_O == DATA_W'($past(REG_RDATA_I) - DATA_W'(CCD_DEC_STEP)))))
		else $error("decrement result or destination wrong");
	AST_DONE: assert property (DONE_O == $past(take) && ($past(take) || (!REG_WE_O && !WDT_CLEAR_O)))
		else $error("completion not one cycle after op");

	COV_CLEAR_WATCHDOG_OP_PRESC: cover property (is_clear_watchdog_op && PRESCALER_TO_WDT_I ##1 PRESCALER_CLEAR_O);
	COV_CMP_BORROW: cover property (is_cmp ##1 !CARRY_FLAG_O);
	COV_DECREMENT_REGISTER_OP_ZERO: cover property (is_decrement_register_op && DEST_I ##1 ZERO_FLAG_O && REG_WE_O);
	COV_BACK_TO_BACK: cover property (take ##1 take ##1 take);
endmodule
`default_nettype wire

// ### verif/tb_ccd_core.sv
// self-checking bench for the clear/compare/decrement datapath
// assumes ccd_pkg is compiled first; register file modelled by REG_RDATA_I
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_core;
	import ccd_pkg::*;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0, dst = 1'b0, pre = 1'b0, wto = 1'b0, slp = 1'b0;
	ccd_op_t op = CCD_OP_NONE;
	logic [5:0] adr = 6'h00, waddr;
	logic [7:0] rd = 8'h00, acc, wdata;
	logic zf, cf, to_n, pd_n, we, wclr, pclr, done;
	int num_errors = 0, checks = 0, cyc = 0;
	ccd_core dut (.CLK_SYS_I(clk), .RESET_I(rst), .OP_VALID_I(vld), .OP_I(op), .REG_ADDR_I(adr),
		.DEST_I(dst), .REG_RDATA_I(rd), .PRESCALER_TO_WDT_I(pre), .WDT_TIMEOUT_I(wto),
		.SLEEP_ENTER_I(slp), .ACC_O(acc), .ZERO_FLAG_O(zf), .CARRY_FLAG_O(cf),
		.TIMEOUT_STATUS_N_O(to_n), .POWERDOWN_STATUS_N_O(pd_n), .REG_WE_O(we),
		.REG_WADDR_O(waddr), .REG_WDATA_O(wdata), .WDT_CLEAR_O(wclr),
		.PRESCALER_CLEAR_O(pclr), .DONE_O(done));
	always #2 clk = ~clk;
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// inputs change at the falling edge, outputs read just after the rising one
	task automatic run(input ccd_op_t o, input logic [5:0] a, input logic d, input logic [7:0] r);
		@(negedge clk);
		vld = 1'b1;
		op = o;
		adr = a;
		dst = d;
		rd = r;
		@(posedge clk);
		#1;
		chk({7'h00, done}, 8'h01, "done");
	endtask
	task automatic idle();
		@(negedge clk);
		vld = 1'b0;
		wto = 1'b0;
		slp = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_clear_accumulator_op();
		run(CCD_DECREMENT_REGISTER_OP, 6'h05, CCD_DEST_ACC, 8'h56);
		chk(acc, 8'h55, "dec to acc");
		run(CCD_CLEAR_ACCUMULATOR_OP, 6'h00, 1'b0, 8'hAA);
		chk(acc, 8'h00, "clear_accumulator_op acc");
		chk({zf, cf, we}, 8'h04, "clear_accumulator_op flags");
		$display("test clear_accumulator_op done");
	endtask
	task automatic t_clear_watchdog_op();
		idle();
		@(negedge clk);
		wto = 1'b1;
		slp = 1'b1;
		idle();
		chk({to_n, pd_n}, 8'h00, "status low");
		run(CCD_CLEAR_WATCHDOG_OP, 6'h00, 1'b0, 8'h00);
		chk({wclr, pclr, to_n, pd_n, zf}, 8'h1F, "clear_watchdog_op pre");
		pre = 1'b0;
		run(CCD_CLEAR_WATCHDOG_OP, 6'h00, 1'b0, 8'h00);
		chk({wclr, pclr, to_n, pd_n}, 8'h0B, "clear_watchdog_op timer");
		$display("test clear_watchdog_op done");
	endtask
	task automatic t_regops();
		run(CCD_CLEAR_REGISTER_OP, 6'h3F, 1'b0, 8'h55);
		chk({we, zf, 2'b00, 4'h0}, 8'hC0, "clear_register_op flags");
		chk({2'b00, waddr}, 8'h3F, "clear_register_op addr");
		chk(wdata, 8'h00, "clear_register_op data");
		run(CCD_COMPLEMENT_REGISTER_OP, 6'h01, CCD_DEST_REG, 8'hA6);
		chk(wdata, 8'h59, "complement_register_op data");
		chk({we, zf}, 8'h02, "complement_register_op flags");
		run(CCD_COMPLEMENT_REGISTER_OP, 6'h02, CCD_DEST_ACC, 8'hFF);
		chk({acc[6:0], we}, 8'h00, "complement_register_op acc");
		chk({7'h00, zf}, 8'h01, "complement_register_op zero");
		run(CCD_DECREMENT_REGISTER_OP, 6'h03, CCD_DEST_REG, 8'h01);
		chk({we, zf, wdata[5:0]}, 8'hC0, "decrement_register_op reg");
		run(CCD_DECREMENT_REGISTER_OP, 6'h04, CCD_DEST_ACC, 8'h00);
		chk(acc, 8'hFF, "decrement_register_op wrap");
		chk({we, zf}, 8'h00, "decrement_register_op flags");
		$display("test register ops done");
	endtask
	task automatic t_cmp();
		logic [7:0] r [3] = '{8'h34, 8'h12, 8'h11};
		logic [1:0] zc [3] = '{2'b01, 2'b11, 2'b00};
		run(CCD_COMPLEMENT_REGISTER_OP, 6'h00, CCD_DEST_ACC, 8'hED);
		for (int i = 0; i < 3; i++) begin
			run(CCD_COMPARE_ACC_REGISTER_OP, 6'h07, 1'b0, r[i]);
			chk({6'h00, zf, cf}, {6'h00, zc[i]}, "cmp flags");
			chk({acc[6:0], we}, 8'h24, "cmp keeps");
		end
		// the empty code is never taken, so no completion strobe follows
		@(negedge clk);
		op = CCD_OP_NONE;
		@(posedge clk);
		#1;
		chk({done, we, wclr, pclr}, 8'h00, "none op");
		idle();
		chk({done, we, wclr, pclr}, 8'h00, "no op");
		$display("test compare done");
	endtask
	// ****************************************
	// sequence and timeout
	// ****************************************
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		pre = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		#1;
		chk(acc, 8'h00, "rst acc");
		chk({zf, cf, to_n, pd_n, we, done}, 8'h0C, "rst flags");
		t_clear_accumulator_op();
		t_clear_watchdog_op();
		t_regops();
		t_cmp();
		results();
	end
endmodule
`default_nettype wire
